// file: frlc_defines.svh
// register offsets, field positions and reset values of the fault report latch control block
`ifndef FRLC_DEFINES_SVH
`define FRLC_DEFINES_SVH

`define FRLC_ADDR_W 8
`define FRLC_OFF_FAULT_STATUS 8'h72
`define FRLC_OFF_WARN_STATUS 8'h73
`define FRLC_OFF_LATCH_MASK 8'h75
`define FRLC_OFF_MISC 8'h76
`define FRLC_OFF_LIMIT_CTRL 8'h77
`define FRLC_OFF_FAULT_CLEAR 8'h78

`define FRLC_RST_LATCH_MASK 8'hF8
`define FRLC_RST_MISC 8'h00
`define FRLC_RST_LIMIT_CTRL 8'h00

`define FRLC_B_LIMIT_FAULT_LATCH_EN 7
`define FRLC_B_LIMIT_WARN_LATCH_EN 6
`define FRLC_B_CLOCK_FAULT_LATCH_EN 5
`define FRLC_B_THERMAL_SHUTDOWN_LATCH_EN 4
`define FRLC_B_THERMAL_WARN_LATCH_EN 3
`define FRLC_B_THERMAL_WARN_MASK 2
`define FRLC_B_LIMIT_WARN_MASK 1
`define FRLC_B_LIMIT_FAULT_MASK 0

`define FRLC_B_CLOCK_DETECT_LATCH 7
`define FRLC_B_THERMAL_AUTO_RECOVER_EN 4

`define FRLC_B_LIMIT_FUNCTION_EN 2
`define FRLC_B_LIMIT_WARNING_GEN_EN 1
`define FRLC_B_LIMIT_FAULT_GEN_EN 0

`define FRLC_B_ANALOG_FAULT_CLEAR 7

`define FRLC_B_STAT_THERMAL_SHUTDOWN 0
`define FRLC_B_STAT_LEFT_LIMIT_FAULT 1
`define FRLC_B_STAT_RIGHT_LIMIT_FAULT 2
`define FRLC_B_WARN_LEFT_LIMIT 5
`define FRLC_B_WARN_RIGHT_LIMIT 4

`endif

// file: frlc_pkg.sv
// types shared by the fault report latch control block
package frlc_pkg;
    typedef logic [7:0] frlc_byte_t;
    typedef logic [3:0] frlc_thermal_level_t;
endpackage

// file: frlc_fault_latch_ctrl.sv
// fault report latch and mask control with its register bank
// Function
// RULE1 - A cycle current limit fault is held latched while limit_fault_latch_en (bit 7, reset 1) is set, else shown live.
// RULE2 - Cycle current limit warnings are latched while limit_warn_latch_en (bit 6, reset 1) is set, else follow the live condition.
// RULE3 - A clock fault is latched while clock_fault_latch_en (bit 5, reset 1) is set and is not held after it ends otherwise.
// RULE4 - A thermal shutdown fault is latched while thermal_shutdown_latch_en (bit 4, reset 1) is set.
// RULE5 - Thermal warnings are latched while thermal_warn_latch_en (bit 3, reset 1) is set, else shown unlatched.
// RULE6 - Setting thermal_warn_mask (bit 2, reset 0) keeps thermal warnings out of the fault report output.
// RULE7 - Setting limit_warn_mask (bit 1, reset 0) keeps cycle current limit warnings out of the fault report output.
// RULE8 - Setting limit_fault_mask (bit 0, reset 0) keeps cycle current limit faults out of the fault report output.
// RULE9 - Clock detection status is latched when clock_detect_latch (misc bit 7, reset 0) is 1 and follows live detection when 0.
// RULE10 - With thermal_auto_recover_en (bit 4, reset 0) set, thermal shutdown ends by itself when the condition ends, else it needs a clear.
// RULE11 - The current limit control register at 77h (reset 00h) enables the function (bit 2), warnings (bit 1) and faults (bit 0).
// RULE12 - Writing 1 to bit 7 of the fault clear register clears all latched analog fault status.
// RULE13 - Left and right cycle current limit faults read in bits 1 and 2 of status register 72h, thermal shutdown in bit 0.
// RULE14 - Left and right cycle current limit warnings read in bits 5 and 4 of register 73h, thermal warning levels in bits 3 to 0.
// RULE15 - The fault clear bit acts as a one cycle pulse, reads back 0, and writing 0 to it does nothing.
`timescale 1ns/1ps
`include "frlc_defines.svh"

module frlc_fault_latch_ctrl
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic left_limit_fault_raw_i,
    input wire logic right_limit_fault_raw_i,
    input wire logic left_limit_warn_raw_i,
    input wire logic right_limit_warn_raw_i,
    input wire logic clock_fault_raw_i,
    input wire logic clock_detect_raw_i,
    input wire logic thermal_shutdown_raw_i,
    input wire logic [3:0] thermal_warning_raw_i,
    output logic [7:0] reg_rdata_o,
    output logic limit_function_en_o,
    output logic fault_report_o,
    output logic thermal_shutdown_o,
    output logic clock_fault_o,
    output logic clock_detect_o
);

    frlc_pkg::frlc_byte_t latch_mask_r, latch_mask_nxt;
    frlc_pkg::frlc_byte_t misc_r, misc_nxt;
    frlc_pkg::frlc_byte_t limit_ctrl_r, limit_ctrl_nxt;
    logic clear_pulse_r, clear_pulse_nxt;
    logic [1:0] limit_fault_r, limit_fault_nxt;
    logic [1:0] limit_warn_r, limit_warn_nxt;
    frlc_pkg::frlc_thermal_level_t thermal_warn_r, thermal_warn_nxt;
    logic clock_fault_r, clock_fault_nxt;
    logic clock_detect_r, clock_detect_nxt;
    logic thermal_shutdown_r, thermal_shutdown_nxt;
    frlc_pkg::frlc_byte_t rdata_nxt;
    logic report_nxt;
    logic [1:0] limit_fault_live;
    logic [1:0] limit_warn_live;

    // latched status: set wins over clear, held only while latch enabled
    function automatic logic hold_status(input logic held, input logic live, input logic latch_en,
                                         input logic clr);
        hold_status = live | (latch_en & held & ~clr);
    endfunction

    // register writes and the clear pulse
    // the clear acts one edge after its write, so a fresh event in that cycle still sets its status
    always_comb
    begin
        latch_mask_nxt = latch_mask_r;
        misc_nxt = misc_r;
        limit_ctrl_nxt = limit_ctrl_r;
        clear_pulse_nxt = 1'b0;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                `FRLC_OFF_LATCH_MASK: latch_mask_nxt = reg_wdata_i;
                `FRLC_OFF_MISC: misc_nxt = reg_wdata_i;
                `FRLC_OFF_LIMIT_CTRL: limit_ctrl_nxt = reg_wdata_i; // [RULE11]
                `FRLC_OFF_FAULT_CLEAR: clear_pulse_nxt = reg_wdata_i[`FRLC_B_ANALOG_FAULT_CLEAR]; // [RULE12] [RULE15]
                default: clear_pulse_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // control registers come up with the latch mask enables set, clock_detect_latch at 0 and nothing masked
            latch_mask_r <= `FRLC_RST_LATCH_MASK;
            misc_r <= `FRLC_RST_MISC;
            limit_ctrl_r <= `FRLC_RST_LIMIT_CTRL;
            clear_pulse_r <= 1'b0;
        end
        else
        begin
            latch_mask_r <= latch_mask_nxt;
            misc_r <= misc_nxt;
            limit_ctrl_r <= limit_ctrl_nxt;
            clear_pulse_r <= clear_pulse_nxt;
        end
    end

    // live conditions gated by the current limit enables
    // a disabled path hides the raw condition from both the latch and the report
    always_comb
    begin
        limit_fault_live = {right_limit_fault_raw_i, left_limit_fault_raw_i}
            & {2{limit_ctrl_r[`FRLC_B_LIMIT_FUNCTION_EN] & limit_ctrl_r[`FRLC_B_LIMIT_FAULT_GEN_EN]}}; // [RULE11]
        limit_warn_live = {right_limit_warn_raw_i, left_limit_warn_raw_i}
            & {2{limit_ctrl_r[`FRLC_B_LIMIT_FUNCTION_EN] & limit_ctrl_r[`FRLC_B_LIMIT_WARNING_GEN_EN]}}; // [RULE11]
    end

    // status latching
    // clearing a latch enable drops a held status at once; the live input still shows
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            limit_fault_nxt[i] = hold_status(limit_fault_r[i], limit_fault_live[i],
                latch_mask_r[`FRLC_B_LIMIT_FAULT_LATCH_EN], clear_pulse_r); // [RULE1]
            limit_warn_nxt[i] = hold_status(limit_warn_r[i], limit_warn_live[i],
                latch_mask_r[`FRLC_B_LIMIT_WARN_LATCH_EN], clear_pulse_r); // [RULE2]
        end
        for (int j = 0; j < 4; j++)
        begin
            thermal_warn_nxt[j] = hold_status(thermal_warn_r[j], thermal_warning_raw_i[j],
                latch_mask_r[`FRLC_B_THERMAL_WARN_LATCH_EN], clear_pulse_r); // [RULE5]
        end
        clock_fault_nxt = hold_status(clock_fault_r, clock_fault_raw_i,
            latch_mask_r[`FRLC_B_CLOCK_FAULT_LATCH_EN], clear_pulse_r); // [RULE3]
        clock_detect_nxt = hold_status(clock_detect_r, clock_detect_raw_i,
            misc_r[`FRLC_B_CLOCK_DETECT_LATCH], clear_pulse_r); // [RULE9]
        // auto recovery lets the shutdown drop with the condition, overriding the latch
        thermal_shutdown_nxt = hold_status(thermal_shutdown_r, thermal_shutdown_raw_i,
            latch_mask_r[`FRLC_B_THERMAL_SHUTDOWN_LATCH_EN] & ~misc_r[`FRLC_B_THERMAL_AUTO_RECOVER_EN],
            clear_pulse_r); // [RULE4] [RULE10] [RULE12]
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // no status is held out of reset
            limit_fault_r <= 2'h0;
            limit_warn_r <= 2'h0;
            thermal_warn_r <= 4'h0;
            clock_fault_r <= 1'b0;
            clock_detect_r <= 1'b0;
            thermal_shutdown_r <= 1'b0;
        end
        else
        begin
            limit_fault_r <= limit_fault_nxt;
            limit_warn_r <= limit_warn_nxt;
            thermal_warn_r <= thermal_warn_nxt;
            clock_fault_r <= clock_fault_nxt;
            clock_detect_r <= clock_detect_nxt;
            thermal_shutdown_r <= thermal_shutdown_nxt;
        end
    end

    // read mux and fault report
    // reads return status held before this edge, so a read and a new event in one cycle show the old state
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `FRLC_OFF_FAULT_STATUS:
                begin
                    rdata_nxt[`FRLC_B_STAT_THERMAL_SHUTDOWN] = thermal_shutdown_r; // [RULE13]
                    rdata_nxt[`FRLC_B_STAT_LEFT_LIMIT_FAULT] = limit_fault_r[0]; // [RULE13]
                    rdata_nxt[`FRLC_B_STAT_RIGHT_LIMIT_FAULT] = limit_fault_r[1]; // [RULE13]
                end
                `FRLC_OFF_WARN_STATUS:
                begin
                    rdata_nxt[`FRLC_B_WARN_LEFT_LIMIT] = limit_warn_r[0]; // [RULE14]
                    rdata_nxt[`FRLC_B_WARN_RIGHT_LIMIT] = limit_warn_r[1]; // [RULE14]
                    rdata_nxt[3:0] = thermal_warn_r; // [RULE14]
                end
                `FRLC_OFF_LATCH_MASK: rdata_nxt = latch_mask_r;
                `FRLC_OFF_MISC: rdata_nxt = misc_r;
                `FRLC_OFF_LIMIT_CTRL: rdata_nxt = limit_ctrl_r;
                `FRLC_OFF_FAULT_CLEAR: rdata_nxt = 8'h00; // [RULE15]
                default: rdata_nxt = 8'h00;
            endcase
        end
        // shutdown and clock faults have no mask bit and always reach the report
        report_nxt = (|limit_fault_nxt & ~latch_mask_r[`FRLC_B_LIMIT_FAULT_MASK]) // [RULE8]
            | (|limit_warn_nxt & ~latch_mask_r[`FRLC_B_LIMIT_WARN_MASK]) // [RULE7]
            | (|thermal_warn_nxt & ~latch_mask_r[`FRLC_B_THERMAL_WARN_MASK]) // [RULE6]
            | thermal_shutdown_nxt | clock_fault_nxt;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // outputs other than read data register next-state values so they move with the status registers
            reg_rdata_o <= 8'h00;
            limit_function_en_o <= 1'b0;
            fault_report_o <= 1'b0;
            thermal_shutdown_o <= 1'b0;
            clock_fault_o <= 1'b0;
            clock_detect_o <= 1'b0;
        end
        else
        begin
            reg_rdata_o <= rdata_nxt;
            limit_function_en_o <= limit_ctrl_nxt[`FRLC_B_LIMIT_FUNCTION_EN]; // [RULE11]
            fault_report_o <= report_nxt;
            thermal_shutdown_o <= thermal_shutdown_nxt;
            clock_fault_o <= clock_fault_nxt;
            clock_detect_o <= clock_detect_nxt;
        end
    end

endmodule

// file: frlc_chk_sva.sv
// port level assertions for the fault report latch control block
`timescale 1ns/1ps
module frlc_chk
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic left_limit_fault_raw_i,
    input wire logic right_limit_fault_raw_i,
    input wire logic left_limit_warn_raw_i,
    input wire logic right_limit_warn_raw_i,
    input wire logic clock_fault_raw_i,
    input wire logic clock_detect_raw_i,
    input wire logic thermal_shutdown_raw_i,
    input wire logic [3:0] thermal_warning_raw_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic limit_function_en_o,
    input wire logic fault_report_o,
    input wire logic thermal_shutdown_o,
    input wire logic clock_fault_o,
    input wire logic clock_detect_o
);
default clocking cb @(posedge ref_clk_i);
endclocking
default disable iff (!rst_n_i);
idle_read_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data not idle");
clear_read_a: assert property (reg_rd_i && reg_addr_i == 8'h78 |=> reg_rdata_o == 8'h00)
    else $error("clear register read not zero");
limit_en_a: assert property (reg_wr_i && reg_addr_i == 8'h77 |=> limit_function_en_o == $past(reg_wdata_i[2]))
    else $error("limit enable not written");
latch_rb_a: assert property (reg_wr_i && reg_addr_i == 8'h75 ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'h75
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("latch register readback wrong");
tsd_live_a: assert property (thermal_shutdown_raw_i |=> thermal_shutdown_o && fault_report_o)
    else $error("shutdown not reported");
clock_fault_a: assert property (clock_fault_raw_i |=> clock_fault_o) else $error("clock fault not shown");
detect_live_a: assert property (clock_detect_raw_i |=> clock_detect_o) else $error("clock detect not shown");
fault_pad_a: assert property (reg_rd_i && reg_addr_i == 8'h72 |=> reg_rdata_o[7:3] == 5'h00)
    else $error("fault status spare bits set");
warn_pad_a: assert property (reg_rd_i && reg_addr_i == 8'h73 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("warning status spare bits set");
cover property (reg_wr_i && reg_addr_i == 8'h78 && reg_wdata_i[7]);
cover property ($rose(fault_report_o));
cover property (reg_rd_i && reg_addr_i == 8'h72 ##1 reg_rdata_o != 8'h00);
endmodule

// file: fault_report_latch_control_test.sv
// random self-checking bench with a reference model of the fault report latch control block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module fault_report_latch_control_test;
logic ref_clk_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
logic left_limit_fault_raw_i = 1'h0, right_limit_fault_raw_i = 1'h0, left_limit_warn_raw_i = 1'h0;
logic right_limit_warn_raw_i = 1'h0, clock_fault_raw_i = 1'h0, clock_detect_raw_i = 1'h0, thermal_shutdown_raw_i = 1'h0;
logic [3:0] thermal_warning_raw_i = 4'h0, tw;
logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, m75, m76, m77, mrd;
logic limit_function_en_o, fault_report_o, thermal_shutdown_o, clock_fault_o, clock_detect_o;
logic [1:0] lf, lw;
logic tsd, cf, cd, clrq, rep;
int fail_count = 0, n_checks = 0;
frlc_fault_latch_ctrl dut_u (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .left_limit_fault_raw_i, .right_limit_fault_raw_i, .left_limit_warn_raw_i, .right_limit_warn_raw_i,
    .clock_fault_raw_i, .clock_detect_raw_i, .thermal_shutdown_raw_i, .thermal_warning_raw_i, .reg_rdata_o,
    .limit_function_en_o, .fault_report_o, .thermal_shutdown_o, .clock_fault_o, .clock_detect_o);
initial
begin
    forever #50 ref_clk_i = ~ref_clk_i;
end
// reference model: old register values act at each edge, writes land last
always @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
        {m75, m76, m77, mrd} = {8'hF8, 8'h00, 8'h00, 8'h00};
        {lf, lw, tw, tsd, cf, cd, clrq, rep} = 13'h0000;
    end
    else
    begin
        case (reg_rd_i ? reg_addr_i : 8'h00)
            8'h72: mrd = {5'h00, lf, tsd};
            8'h73: mrd = {2'h0, lw[0], lw[1], tw};
            8'h75: mrd = m75;
            8'h76: mrd = m76;
            8'h77: mrd = m77;
            default: mrd = 8'h00;
        endcase
        lf = {right_limit_fault_raw_i, left_limit_fault_raw_i} & {2{m77[2] & m77[0]}} | lf & {2{m75[7] & !clrq}};
        lw = {right_limit_warn_raw_i, left_limit_warn_raw_i} & {2{m77[2] & m77[1]}} | lw & {2{m75[6] & !clrq}};
        tw = thermal_warning_raw_i | tw & {4{m75[3] & !clrq}};
        tsd = thermal_shutdown_raw_i | tsd & m75[4] & !m76[4] & !clrq;
        cf = clock_fault_raw_i | cf & m75[5] & !clrq;
        cd = clock_detect_raw_i | cd & m76[7] & !clrq;
        rep = |(lf & ~{2{m75[0]}}) | |(lw & ~{2{m75[1]}}) | |(tw & ~{4{m75[2]}}) | tsd | cf;
        clrq = reg_wr_i && reg_addr_i == 8'h78 && reg_wdata_i[7];
        if (reg_wr_i && reg_addr_i == 8'h75) m75 = reg_wdata_i;
        if (reg_wr_i && reg_addr_i == 8'h76) m76 = reg_wdata_i;
        if (reg_wr_i && reg_addr_i == 8'h77) m77 = reg_wdata_i;
    end
task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
// compare, then drive sparse random conditions and register traffic, with one reset pulse in mid-run;
// the seed is set in this process so that it governs the stimulus
initial
begin
    void'($urandom(32'hB6AE));
    repeat (10) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'h1;
    for (int k = 0; k < 3000; k++)
    begin
        @(negedge ref_clk_i);
        `CHK("rdata", mrd, reg_rdata_o)
        `CHK("report", rep, fault_report_o)
        `CHK("shutdown", tsd, thermal_shutdown_o)
        `CHK("clkfault", cf, clock_fault_o)
        `CHK("detect", cd, clock_detect_o)
        `CHK("limit_en", m77[2], limit_function_en_o)
        rst_n_i = (k != 1500);
        {left_limit_fault_raw_i, right_limit_fault_raw_i, left_limit_warn_raw_i, right_limit_warn_raw_i,
            clock_fault_raw_i, clock_detect_raw_i, thermal_shutdown_raw_i} = 7'($urandom & $urandom & $urandom);
        thermal_warning_raw_i = 4'($urandom & $urandom & $urandom);
        reg_wr_i = ($urandom % 3) == 0;
        reg_rd_i = ($urandom % 2) == 0;
        reg_addr_i = 8'h70 + 8'($urandom % 10);
        reg_wdata_i = 8'($urandom);
    end
    give_verdict();
end
initial
begin
    repeat (5000) @(posedge ref_clk_i);
    fail_count++;
    give_verdict();
end
endmodule
bind frlc_fault_latch_ctrl frlc_chk chk_u (.ref_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .left_limit_fault_raw_i, .right_limit_fault_raw_i, .left_limit_warn_raw_i, .right_limit_warn_raw_i,
    .clock_fault_raw_i, .clock_detect_raw_i, .thermal_shutdown_raw_i, .thermal_warning_raw_i, .reg_rdata_o,
    .limit_function_en_o, .fault_report_o, .thermal_shutdown_o, .clock_fault_o, .clock_detect_o);
